// [acr_pkg.sv]
// Package with register map, field layout and shared types
package acr_pkg;

    // ==========================================================
    // Register select codes (instruction bits 3:2)
    // ==========================================================
    localparam logic [1:0] SEL_GLOBAL   = 2'h0;
    localparam logic [1:0] SEL_TBL_LOW  = 2'h1;
    localparam logic [1:0] SEL_TBL_UP   = 2'h2;
    localparam logic [1:0] SEL_RAM      = 2'h3;

    // ==========================================================
    // Global control word fields
    // ==========================================================
    localparam int GC_HELD_HI   = 15;
    localparam int GC_HELD_LO   = 13;
    localparam int GC_CHOP_N    = 12;
    localparam int GC_QUIET     = 11;
    localparam int GC_LNF       = 10;
    localparam int GC_MAINS     = 9;
    localparam int GC_TWOS      = 8;
    localparam int GC_CNT_HI    = 7;
    localparam int GC_CNT_LO    = 5;
    localparam int GC_TWO_PT    = 4;
    localparam int GC_SLEEP     = 3;
    localparam int GC_BYTE_UP   = 2;
    localparam int GC_LSB_FIRST = 1;
    localparam int GC_THREE_W   = 0;
    localparam logic [15:0] GC_RESET   = 16'h0000;
    localparam logic [15:0] GC_WR_MASK = 16'h1fff;

    // ==========================================================
    // Channel byte fields
    // ==========================================================
    localparam int CB_PHYS_HI = 7;
    localparam int CB_PHYS_LO = 5;
    localparam int CB_BIPOLAR = 4;
    localparam int CB_OP_HI   = 3;
    localparam int CB_OP_LO   = 2;
    localparam int CB_GAIN_HI = 1;
    localparam int CB_GAIN_LO = 0;
    localparam logic [63:0] TBL_RESET = 64'h0;
    localparam logic [1:0]  OP_NORMAL = 2'h0;

    // ==========================================================
    // Scan timing
    // ==========================================================
    localparam int          CONV_NS     = 1000;
    localparam int          CLK_NS      = 50;
    localparam logic [7:0]  CONV_CYC    = 8'(CONV_NS / CLK_NS);
    localparam logic [2:0]  FILL_SCANS  = 3'h4;

    // Byte-wide register access from the serial engine
    typedef struct packed {
        logic       wr;
        logic [1:0] sel;
        logic [1:0] idx;
        logic [7:0] data;
    } acr_acc_t;

    // Settings presented to the analog and conversion path
    typedef struct packed {
        logic       chop_bypass;
        logic       lnf_on;
        logic       mains_50;
        logic       twos;
        logic       two_point;
        logic [2:0] phys;
        logic       bipolar;
        logic [1:0] op;
        logic [1:0] gain;
    } acr_conv_t;

    // Serial port format choices
    typedef struct packed {
        logic byte_up;
        logic lsb_first;
        logic three_wire;
    } acr_fmt_t;

    typedef enum logic [1:0] {
        SC_SLEEP = 2'b00,
        SC_CONV  = 2'b01,
        SC_DONE  = 2'b10
    } acr_scan_t;

endpackage : acr_pkg

// [acr_byte_lane.sv]
// One channel byte of the table with calibration self-clear
`timescale 1ns/100ps
module acr_byte_lane (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic       cal_done,
    output logic      [7:0] value
);
    typedef struct packed {
        logic [7:0] b;
    } acr_lane_t;

    acr_lane_t st_q;
    acr_lane_t st_d;

    always_comb begin
        st_d = st_q;
        if (cal_done) begin
            st_d.b[acr_pkg::CB_OP_HI:acr_pkg::CB_OP_LO] =
                acr_pkg::OP_NORMAL;
        end
        if (wr) begin
            st_d.b = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.b;
endmodule : acr_byte_lane

// [acr_regs.sv]
// Global control word, channel table and scan sequencer
// Summary of operation
// - Bit 12 low uses chopper path
// - Bit 11 hides scan-done during active cal
// - Bit 10 enables line-noise filtering
// - Bit 9 one picks 50Hz, zero 60Hz
// - Bit 8 selects twos complement for bipolar
// - Bits 7:5 plus one channels scanned
// - Bit 4 selects two-point calibration
// - Sleep stops scan, clears filters, scan-done
// - Leaving sleep restarts at channel one
// - First done after four or one scans
// - Bit 2 one ascending byte order
// - Bit 1 one sends LSB first
// - Bit 0 one selects three-wire
// - Table is two words, byte accessible
// - Upper word holds channels one to four
// - Table bytes writable while scanning
// - Byte bits 7:5 select physical input
// - Byte bit 4 one means bipolar
// - Byte bits 3:2 select operation
// - Calibration mode returns to normal itself
// - Byte bits 1:0 select gain
// - Instruction bits 3:2 select register
// - Scan-done low until result RAM read
`timescale 1ns/100ps
module acr_regs (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  acr_pkg::acr_acc_t     acc,
    input  wire logic             ram_read_done,
    output logic [7:0]            rd_data,
    output acr_pkg::acr_conv_t    conv,
    output acr_pkg::acr_fmt_t     fmt,
    output logic [2:0]            chan_ptr,
    output logic                  conv_start,
    output logic                  lnf_clear,
    output logic                  cal_active,
    output logic                  scan_done_n
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [15:0]        gcw;
        acr_pkg::acr_scan_t scan;
        logic [2:0]         ptr;
        logic [7:0]         cyc;
        logic [2:0]         fill;
        logic               cal_seen;
        logic [7:0]         slot;
        logic               done_n;
        logic [7:0]         rd;
        acr_pkg::acr_conv_t conv;
        acr_pkg::acr_fmt_t  fmt;
        logic               start;
        logic               lnf_clr;
        logic               cal_out;
    } acr_st_t;

    acr_st_t     st_q;
    acr_st_t     st_d;
    logic [63:0] table_w;
    logic [7:0]  lane_wr;
    logic [7:0]  lane_cal;
    logic [2:0]  cnt;
    logic        sleep;
    logic        last_slot;
    logic        conv_end;
    logic        any_cal;
    logic [2:0]  fill_need;

    assign cnt   = st_q.gcw[acr_pkg::GC_CNT_HI:acr_pkg::GC_CNT_LO];
    assign sleep = st_q.gcw[acr_pkg::GC_SLEEP];
    assign conv_end  = (st_q.scan == acr_pkg::SC_CONV) &&
                       (st_q.cyc == acr_pkg::CONV_CYC - 8'h01);
    assign last_slot = (st_q.ptr == cnt);

    // ==========================================================
    // Channel table lanes
    // ==========================================================
    // Lane i holds logical channel i+1, upper word first
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_lane
            localparam logic [1:0] SEL =
                (gi < 4) ? acr_pkg::SEL_TBL_UP : acr_pkg::SEL_TBL_LOW;
            localparam logic [1:0] IDX = 2'(3 - (gi % 4));
            assign lane_wr[gi] = acc.wr && acc.sel == SEL &&
                                 acc.idx == IDX;
            assign lane_cal[gi] = conv_end &&
                                  st_q.ptr == 3'(gi) &&
                                  st_q.conv.op != acr_pkg::OP_NORMAL;
            acr_byte_lane u_lane (
                .clk      (clk),
                .rst_b    (rst_b),
                .wr       (lane_wr[gi]),
                .wdata    (acc.data),
                .cal_done (lane_cal[gi]),
                .value    (table_w[63 - 8*gi -: 8])
            );
        end
    endgenerate

    // Calibration mode on any active channel
    always_comb begin
        any_cal = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (3'(i) <= cnt &&
                table_w[63 - 8*i - 4 -: 2] != acr_pkg::OP_NORMAL) begin
                any_cal = 1'b1;
            end
        end
    end

    assign fill_need = st_q.gcw[acr_pkg::GC_LNF] ?
                       acr_pkg::FILL_SCANS : 3'h1;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_d         = st_q;
        st_d.start   = 1'b0;
        st_d.lnf_clr = 1'b0;

        // Register writes; instruction bits 3:2 pick the target
        if (acc.wr && acc.sel == acr_pkg::SEL_GLOBAL) begin
            if (acc.idx == 2'h0) begin
                st_d.gcw[7:0] = acc.data;
            end else if (acc.idx == 2'h1) begin
                st_d.gcw[15:8] = acc.data &
                                 acr_pkg::GC_WR_MASK[15:8];
            end
        end

        // Readback
        st_d.rd = 8'h00;
        if (acc.sel == acr_pkg::SEL_GLOBAL) begin
            if (acc.idx == 2'h0) begin
                st_d.rd = st_q.gcw[7:0];
            end else if (acc.idx == 2'h1) begin
                st_d.rd = st_q.gcw[15:8];
            end
        end else if (acc.sel == acr_pkg::SEL_TBL_UP) begin
            st_d.rd = table_w[63 - 8*(3 - acc.idx) -: 8];
        end else if (acc.sel == acr_pkg::SEL_TBL_LOW) begin
            st_d.rd = table_w[31 - 8*(3 - acc.idx) -: 8];
        end

        // Global settings to the conversion and serial paths
        st_d.conv.chop_bypass = st_q.gcw[acr_pkg::GC_CHOP_N];
        st_d.conv.lnf_on      = st_q.gcw[acr_pkg::GC_LNF];
        st_d.conv.mains_50    = st_q.gcw[acr_pkg::GC_MAINS];
        st_d.conv.two_point   = st_q.gcw[acr_pkg::GC_TWO_PT];
        st_d.fmt.byte_up      = st_q.gcw[acr_pkg::GC_BYTE_UP];
        st_d.fmt.lsb_first    = st_q.gcw[acr_pkg::GC_LSB_FIRST];
        st_d.fmt.three_wire   = st_q.gcw[acr_pkg::GC_THREE_W];
        st_d.cal_out          = any_cal && !sleep;

        if (ram_read_done) begin
            st_d.done_n = 1'b1;
        end

        case (st_q.scan)
            acr_pkg::SC_SLEEP: begin
                if (!sleep) begin
                    st_d.scan     = acr_pkg::SC_CONV;
                    st_d.ptr      = 3'h0;
                    st_d.cyc      = 8'h00;
                    st_d.fill     = 3'h0;
                    st_d.cal_seen = 1'b0;
                    st_d.slot     = table_w[63:56];
                    st_d.start    = 1'b1;
                end
            end
            acr_pkg::SC_CONV: begin
                st_d.cyc = st_q.cyc + 8'h01;
                if (conv_end) begin
                    st_d.cyc = 8'h00;
                    if (st_q.conv.op != acr_pkg::OP_NORMAL) begin
                        st_d.cal_seen = 1'b1;
                    end
                    if (last_slot) begin
                        st_d.ptr = 3'h0;
                        if (st_q.fill < fill_need) begin
                            st_d.fill = st_q.fill + 3'h1;
                        end
                        st_d.scan = acr_pkg::SC_DONE;
                    end else begin
                        st_d.ptr = st_q.ptr + 3'h1;
                    end
                    // Byte is latched only at slot start
                    st_d.slot  = table_w[63 - 8*st_d.ptr -: 8];
                    // Take the lane's next value: a write or a cal clear
                    // landing on this edge must not be missed
                    if (lane_wr[st_d.ptr]) begin
                        st_d.slot = acc.data;
                    end else if (lane_cal[st_d.ptr]) begin
                        st_d.slot[acr_pkg::CB_OP_HI:acr_pkg::CB_OP_LO] =
                            acr_pkg::OP_NORMAL;
                    end
                    st_d.start = 1'b1;
                end
            end
            acr_pkg::SC_DONE: begin
                // Scan boundary: decide whether to report
                st_d.scan = acr_pkg::SC_CONV;
                st_d.cal_seen = 1'b0;
                if (st_q.fill >= fill_need &&
                    !(st_q.gcw[acr_pkg::GC_QUIET] &&
                      (st_q.cal_seen || any_cal))) begin
                    st_d.done_n = 1'b0;
                end
            end
            default: begin
                st_d.scan = acr_pkg::SC_SLEEP;
            end
        endcase

        st_d.conv.phys    = st_d.slot[acr_pkg::CB_PHYS_HI:
                                      acr_pkg::CB_PHYS_LO];
        st_d.conv.bipolar = st_d.slot[acr_pkg::CB_BIPOLAR];
        st_d.conv.twos    = st_q.gcw[acr_pkg::GC_TWOS] &
                            st_d.conv.bipolar;
        st_d.conv.op      = st_d.slot[acr_pkg::CB_OP_HI:
                                      acr_pkg::CB_OP_LO];
        st_d.conv.gain    = st_d.slot[acr_pkg::CB_GAIN_HI:
                                      acr_pkg::CB_GAIN_LO];

        // Sleep overrides everything in the scan path
        if (sleep) begin
            st_d.scan    = acr_pkg::SC_SLEEP;
            st_d.ptr     = 3'h0;
            st_d.cyc     = 8'h00;
            st_d.fill    = 3'h0;
            st_d.done_n  = 1'b1;
            st_d.start   = 1'b0;
            st_d.lnf_clr = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q        <= '0;
            st_q.gcw    <= acr_pkg::GC_RESET;
            st_q.scan   <= acr_pkg::SC_SLEEP;
            st_q.done_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data     = st_q.rd;
    assign conv        = st_q.conv;
    assign fmt         = st_q.fmt;
    assign chan_ptr    = st_q.ptr;
    assign conv_start  = st_q.start;
    assign lnf_clear   = st_q.lnf_clr;
    assign cal_active  = st_q.cal_out;
    assign scan_done_n = st_q.done_n;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_held_zero;
        @(posedge clk) disable iff (!rst_b)
        st_q.gcw[15:13] == 3'h0;
    endproperty
    a_held_zero: assert property (p_held_zero)
        else $error("Held bits of control word not zero");

    property p_chop;
        @(posedge clk) disable iff (!rst_b)
        ##1 conv.chop_bypass == $past(st_q.gcw[acr_pkg::GC_CHOP_N]);
    endproperty
    a_chop: assert property (p_chop)
        else $error("Chop output does not follow bit 12");

    property p_sleep_stops;
        @(posedge clk) disable iff (!rst_b)
        sleep |=> scan_done_n && chan_ptr == 3'h0 && lnf_clear
                  && !conv_start;
    endproperty
    a_sleep_stops: assert property (p_sleep_stops)
        else $error("Sleep did not halt scan");

    property p_wake;
        @(posedge clk) disable iff (!rst_b)
        $fell(sleep) |=> conv_start && chan_ptr == 3'h0;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Wake did not restart at channel one");

    property p_quiet;
        @(posedge clk) disable iff (!rst_b)
        (st_q.scan == acr_pkg::SC_DONE && st_q.gcw[acr_pkg::GC_QUIET]
         && (any_cal || st_q.cal_seen) && !sleep && !ram_read_done)
        |=> $stable(scan_done_n);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Scan-done raised during calibration");

    property p_fill;
        @(posedge clk) disable iff (!rst_b)
        $fell(scan_done_n) |-> $past(st_q.fill) >= $past(fill_need);
    endproperty
    a_fill: assert property (p_fill)
        else $error("Scan-done before filters filled");

    property p_cal_clear;
        @(posedge clk) disable iff (!rst_b)
        lane_cal[0] && !lane_wr[0] |=> table_w[59:58] == 2'h0;
    endproperty
    a_cal_clear: assert property (p_cal_clear)
        else $error("Calibration mode not cleared");

    property p_ram_read;
        @(posedge clk) disable iff (!rst_b)
        ram_read_done && st_q.scan != acr_pkg::SC_DONE |=> scan_done_n;
    endproperty
    a_ram_read: assert property (p_ram_read)
        else $error("Scan-done not released after read");

    property p_lsb;
        @(posedge clk) disable iff (!rst_b)
        ##1 fmt.lsb_first == $past(st_q.gcw[acr_pkg::GC_LSB_FIRST]);
    endproperty
    a_lsb: assert property (p_lsb)
        else $error("Bit order does not follow bit 1");

    property p_slot_hold;
        @(posedge clk) disable iff (!rst_b)
        !conv_start && !lnf_clear |-> $stable(conv.gain);
    endproperty
    a_slot_hold: assert property (p_slot_hold)
        else $error("Channel settings changed mid conversion");

    c_wake: cover property (@(posedge clk) disable iff (!rst_b)
        $fell(sleep));
    c_done: cover property (@(posedge clk) disable iff (!rst_b)
        $fell(scan_done_n));
    c_cal: cover property (@(posedge clk) disable iff (!rst_b)
        |lane_cal);
endmodule : acr_regs

// [acr_host_model.sv]
// Host controller model issuing byte accesses to the register bank
`timescale 1ns/100ps
module acr_host_model (
    input  wire logic        clk,
    input  wire logic [7:0]  rd_data,
    output acr_pkg::acr_acc_t acc,
    output logic             ram_read_done
);
    // Cleared only by a scenario that writes the held bits on purpose
    logic keep_rules;

    initial begin
        keep_rules    = 1'b1;
        acc           = '0;
        ram_read_done = 1'b0;
    end

    task automatic wr_byte(input logic [1:0] sel, input logic [1:0] idx,
                           input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (keep_rules && sel == acr_pkg::SEL_GLOBAL && idx == 2'h1) begin
            d[7:5] = 3'h0;
        end
        repeat ($urandom_range(1, 0)) @(negedge clk);
        @(negedge clk);
        acc <= '{wr: 1'b1, sel: sel, idx: idx, data: d};
        @(negedge clk);
        acc.wr   <= 1'b0;
        acc.data <= ~d;
    endtask : wr_byte

    task automatic rd_byte(input logic [1:0] sel, input logic [1:0] idx,
                           output logic [7:0] data);
        @(negedge clk);
        acc.sel <= sel;
        acc.idx <= idx;
        @(negedge clk);
        data = rd_data;
    endtask : rd_byte

    // Host finished reading the whole result RAM
    task automatic read_done();
        @(negedge clk);
        ram_read_done <= 1'b1;
        @(negedge clk);
        ram_read_done <= 1'b0;
    endtask : read_done
endmodule : acr_host_model

// [adc_scan_config_registers_tb_top.sv]
// Self-checking testbench of the configuration register bank
`timescale 1ns/100ps
module adc_scan_config_registers_tb_top;
    logic               clk;
    logic               rst_b;
    acr_pkg::acr_acc_t  acc;
    logic               ram_read_done;
    logic [7:0]         rd_data;
    acr_pkg::acr_conv_t conv;
    acr_pkg::acr_fmt_t  fmt;
    logic [2:0]         chan_ptr;
    logic               conv_start;
    logic               lnf_clear;
    logic               cal_active;
    logic               scan_done_n;
    int                 failures;
    int                 samples_checked;
    int                 cycles;
    logic [15:0]        gcw;
    logic [15:0]        g;
    logic [7:0]         tbl [8];
    logic [7:0]         rb;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    acr_regs i_dut (
        .clk(clk), .rst_b(rst_b), .acc(acc), .ram_read_done(ram_read_done),
        .rd_data(rd_data), .conv(conv), .fmt(fmt), .chan_ptr(chan_ptr),
        .conv_start(conv_start), .lnf_clear(lnf_clear),
        .cal_active(cal_active), .scan_done_n(scan_done_n)
    );

    acr_host_model i_host (
        .clk(clk), .rd_data(rd_data), .acc(acc),
        .ram_read_done(ram_read_done)
    );

    // ==========================================================
    // Checking and helpers
    // ==========================================================
    task automatic results();
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : check

    function automatic logic [1:0] f_sel(input int c);
        return (c < 4) ? acr_pkg::SEL_TBL_UP : acr_pkg::SEL_TBL_LOW;
    endfunction : f_sel

    function automatic logic [1:0] f_idx(input int c);
        return 2'(3 - c % 4);
    endfunction : f_idx

    task automatic set_gcw(input logic [15:0] v);
        gcw = v & acr_pkg::GC_WR_MASK;
        i_host.wr_byte(acr_pkg::SEL_GLOBAL, 2'h1, v[15:8]);
        i_host.wr_byte(acr_pkg::SEL_GLOBAL, 2'h0, v[7:0]);
    endtask : set_gcw

    task automatic set_chan(input int c, input logic [7:0] v);
        tbl[c] = v;
        i_host.wr_byte(f_sel(c), f_idx(c), v);
    endtask : set_chan

    task automatic check_gcw();
        i_host.rd_byte(acr_pkg::SEL_GLOBAL, 2'h0, rb);
        check(16'(rb), 16'(gcw[7:0]), "global low");
        i_host.rd_byte(acr_pkg::SEL_GLOBAL, 2'h1, rb);
        check(16'(rb), 16'(gcw[15:8]), "global high");
        check(16'(conv.chop_bypass), 16'(gcw[12]), "chop");
        check(16'(conv.lnf_on), 16'(gcw[10]), "filter");
        check(16'(conv.mains_50), 16'(gcw[9]), "mains");
        check(16'(conv.two_point), 16'(gcw[4]), "two point");
        check(16'(fmt.byte_up), 16'(gcw[2]), "byte order");
        check(16'(fmt.lsb_first), 16'(gcw[1]), "bit order");
        check(16'(fmt.three_wire), 16'(gcw[0]), "wires");
    endtask : check_gcw

    task automatic wait_start();
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (conv_start !== 1'b1 && k < 400);
        check(16'(k < 400), 16'h1, "slot start");
    endtask : wait_start

    task automatic check_slot(input int c);
        wait_start();
        repeat (2) @(negedge clk);
        check(16'(chan_ptr), 16'(c), "pointer");
        check(16'(conv.phys), 16'(tbl[c][7:5]), "input");
        check(16'(conv.bipolar), 16'(tbl[c][4]), "range");
        check(16'(conv.op), 16'(tbl[c][3:2]), "operation");
        check(16'(conv.gain), 16'(tbl[c][1:0]), "gain");
        check(16'(conv.twos), 16'(gcw[8] & tbl[c][4]), "coding");
    endtask : check_slot

    // Sleep, then wake and time the first scan-done
    task automatic scan_time(input logic lnf, input int nch);
        int k;
        int fills;
        fills = lnf ? 4 : 1;
        g = {5'h0, lnf, 2'h0, 3'(nch - 1), 5'h0};
        set_gcw(g | 16'h0008);
        repeat (2) @(negedge clk);
        check(16'({lnf_clear, scan_done_n, chan_ptr}), 16'h18, "sleep");
        k = 0;
        repeat (60) begin
            @(negedge clk);
            if (conv_start === 1'b1) k++;
        end
        check(16'(k), 16'h0, "halted");
        check_gcw();
        set_gcw(g);
        k = 0;
        while (scan_done_n !== 1'b0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        check(16'(k >= fills * nch * 20 && k <= fills * (nch * 20 + 2) + 4),
              16'h1, "fill time");
        i_host.read_done();
        repeat (2) @(negedge clk);
        check(16'(scan_done_n), 16'h1, "done release");
    endtask : scan_time

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            results();
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'h55e0));
        rst_b = 1'b0;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        gcw = '0;
        foreach (tbl[i]) tbl[i] = 8'h00;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check(16'(scan_done_n), 16'h1, "done idle");
        check_gcw();
        for (int c = 0; c < 8; c++) begin
            i_host.rd_byte(f_sel(c), f_idx(c), rb);
            check(16'(rb), 16'h0, "table reset");
        end
        // Random control words, first one with the held bits set
        for (int i = 0; i < 4; i++) begin
            g = 16'($urandom) & 16'hfff7;
            i_host.keep_rules = (i != 0);
            if (i == 0) g[15:13] = 3'h7;
            set_gcw(g);
            repeat (2) @(negedge clk);
            check_gcw();
        end
        i_host.keep_rules = 1'b1;
        for (int c = 0; c < 8; c++) set_chan(c, 8'($urandom) & 8'hf3);
        for (int c = 0; c < 8; c++) begin
            i_host.rd_byte(f_sel(c), f_idx(c), rb);
            check(16'(rb), 16'(tbl[c]), "table");
        end
        // Eight channels scanned in table order, then wrap
        g = (16'($urandom) & 16'h1307) | 16'h00e0;
        set_gcw(g | 16'h0008);
        set_gcw(g);
        for (int c = 0; c < 9; c++) check_slot(c % 8);
        scan_time(1'b0, 3);
        scan_time(1'b1, 2);
        // Calibration on an inactive channel is ignored
        set_chan(7, 8'h0c);
        set_gcw(16'h0800);
        repeat (3) @(negedge clk);
        check(16'(cal_active), 16'h0, "inactive cal");
        for (int op = 1; op < 4; op++) begin
            set_gcw(16'h0808);
            set_chan(0, (8'($urandom) & 8'hf3) | 8'(op << 2));
            set_gcw(16'h0800);
            check_slot(0);
            check(16'(cal_active), 16'h1, "cal active");
            wait_start();
            repeat (2) @(negedge clk);
            check(16'(scan_done_n), 16'h1, "done held");
            tbl[0][3:2] = acr_pkg::OP_NORMAL;
            i_host.rd_byte(f_sel(0), f_idx(0), rb);
            check(16'(rb), 16'(tbl[0]), "cal cleared");
            wait_start();
            repeat (2) @(negedge clk);
            check(16'(scan_done_n), 16'h0, "done after cal");
            i_host.read_done();
        end
        // Rewrite during a slot applies at the next slot
        wait_start();
        repeat (5) @(negedge clk);
        rb = 8'(conv.gain);
        set_chan(0, tbl[0] ^ 8'h03);
        repeat (6) @(negedge clk);
        check(16'(conv.gain), 16'(rb[1:0]), "gain held");
        check_slot(0);
        results();
    end
endmodule : adc_scan_config_registers_tb_top
